//--- hw/cesp_core_end.sv
// core logic end: clock stop, snoop phase, result observer, shutdown to nmi
`timescale 1ns/100ps
`include "cesp_defs.svh"
module cesp_core_end
   import cesp_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   cesp_if.core      pins,
   input  wire logic stop_clock,
   input  wire logic snoop_start,
   input  wire logic core_stall,
   input  wire logic nmi_enable,
   output logic      snoop_busy,
   output logic      snoop_done,
   output logic      snoop_shared,
   output logic      snoop_modified,
   output logic      nmi_out,
   output logic      fpu_error_seen,
   output logic      break_seen,
   output logic      fault_seen
);
   cesp_obs_state_t state_reg;
   cesp_obs_state_t state_next;
   logic            shared_reg;
   logic            modified_reg;
   logic            nmi_reg;
   logic            stop_reg;
   // results from the far end are registered there, so the first phase cycle is never judged
   logic            phase_seen_reg;
   wire             both_hits = pins.snoop_hit_wire & pins.snoop_modified_hit_wire;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CESP_IDLE: if (snoop_start) state_next = CESP_WAIT;
         CESP_WAIT: if (phase_seen_reg && !both_hits && !core_stall) state_next = CESP_DONE;
         CESP_DONE: state_next = CESP_IDLE;
         default:   state_next = CESP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg    <= CESP_IDLE;
         shared_reg   <= 1'b0;
         modified_reg <= 1'b0;
         nmi_reg      <= 1'b0;
         stop_reg     <= 1'b0;
         phase_seen_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         phase_seen_reg <= pins.snoop_phase;
         stop_reg  <= stop_clock;
         nmi_reg   <= pins.shutdown_cycle & nmi_enable;
         if (state_reg == CESP_WAIT && state_next == CESP_DONE) begin
            shared_reg   <= pins.snoop_hit_wire;
            modified_reg <= pins.snoop_modified_hit_wire;
         end
      end
   end

   assign pins.clock_stop_request = stop_reg;
   assign pins.snoop_phase        = (state_reg == CESP_WAIT);
   assign pins.core_hit_out       = 1'b1;
   assign pins.core_modified_out  = 1'b1;
   assign pins.core_hit_oe        = pins.snoop_phase & core_stall;
   assign pins.core_modified_oe   = pins.snoop_phase & core_stall;
   assign snoop_busy     = (state_reg == CESP_WAIT);
   assign snoop_done     = (state_reg == CESP_DONE);
   assign snoop_shared   = shared_reg;
   assign snoop_modified = modified_reg;
   assign nmi_out        = nmi_reg;
   assign fpu_error_seen = pins.fpu_error_break_pending_out & ~stop_reg;
   assign break_seen     = pins.fpu_error_break_pending_out & stop_reg;
   assign fault_seen     = pins.internal_fault_out;
endmodule : cesp_core_end

//--- hw/cesp_cpu_end.sv
// processor end: error/break mux, snoop result drive, sticky internal fault
// What this block does
// - no clock stop: pin shows unmasked fpu error
// - clock stop: pin shows pending break event
// - this end reports its snoop result on hit pins; the core end drives both only to stall
// - both hits together mean snoop stall
// - repeated both-hits extends stall; observers keep waiting
// - internal error raises internal fault output
// - internal fault usually issues shutdown transaction
// - core logic may turn shutdown into nmi
// - internal fault stays set until reset
`timescale 1ns/100ps
module cesp_cpu_end
   import cesp_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   cesp_if.cpu       pins,
   input  wire logic fpu_error,
   input  wire logic fpu_error_masked,
   input  wire logic break_pending,
   input  wire logic internal_error,
   input  wire logic shutdown_enable,
   input  wire logic snoop_need_stall,
   input  wire logic snoop_hit_line,
   input  wire logic snoop_modified_line,
   output logic      snoop_stalled,
   output logic      fault_sticky
);
   // all pins here are active high; the board supplies the inversion
   // the two snoop pins are wired-or between agents, so this end only ever pulls them;
   // a stall held by the core end therefore shows here on the wires as well
   // an input that is high for one cycle reaches its pin on the next edge

   // every status pin this end drives leaves a flip-flop; the snoop enables are decoded from result_reg,
   // so the far end sees no decode glitches on the status pins
   logic        err_break_reg;
   logic        err_break_next;
   logic        fault_reg;
   logic        fault_next;
   logic        shutdown_reg;
   logic        shutdown_next;
   cesp_snoop_t result_reg;
   cesp_snoop_t result_next;

   // named decodes of the inputs
   // and of the shared wires
   wire         fpu_unmasked;
   wire         fault_rise;
   wire         phase_open;
   wire         wires_both;

   // shared-hit pin is asserted for a shared result and for a stall
   // a clean or modified result leaves the pin to the other agents
   function automatic logic drives_hit(input cesp_snoop_t code);
      logic hit;
      hit = 1'h0;
      case (code)
         CESP_SNOOP_CLEAN:    hit = 1'h0;
         CESP_SNOOP_SHARED:   hit = 1'h1;
         CESP_SNOOP_MODIFIED: hit = 1'h0;
         CESP_SNOOP_STALL:    hit = 1'h1;
         default:             hit = 1'h0;
      endcase
      return hit;
   endfunction : drives_hit

   // modified-hit pin is asserted for a modified result and for a stall
   // a clean or shared result leaves the pin to the other agents
   function automatic logic drives_modified(input cesp_snoop_t code);
      logic mod;
      mod = 1'h0;
      case (code)
         CESP_SNOOP_CLEAN:    mod = 1'h0;
         CESP_SNOOP_SHARED:   mod = 1'h0;
         CESP_SNOOP_MODIFIED: mod = 1'h1;
         CESP_SNOOP_STALL:    mod = 1'h1;
         default:             mod = 1'h0;
      endcase
      return mod;
   endfunction : drives_modified

   // both pins together are never a result of their own: they always mean a stall
   // whoever holds them, every observer keeps waiting
   function automatic logic is_stall(input logic hit,
                                     input logic modified);
      logic both;
      both = hit & modified;
      return both;
   endfunction : is_stall

   // stall outranks modified, modified outranks shared; outside the phase the clean code is picked
   // limitation: a line both shared and modified is reported as modified only
   function automatic cesp_snoop_t pick_result(input logic phase,
                                               input logic stall,
                                               input logic modified,
                                               input logic hit);
      cesp_snoop_t code;
      code = CESP_SNOOP_CLEAN;
      if (!phase) begin
         code = CESP_SNOOP_CLEAN;
      end else if (stall) begin
         code = CESP_SNOOP_STALL;
      end else if (modified) begin
         code = CESP_SNOOP_MODIFIED;
      end else if (hit) begin
         code = CESP_SNOOP_SHARED;
      end else begin
         code = CESP_SNOOP_CLEAN;
      end
      return code;
   endfunction : pick_result

   // the stop request decides which meaning the shared error/break pin carries
   // a break event with no stop request, or an fpu error under one, is not shown
   function automatic logic pick_err_break(input logic stop_req,
                                           input logic brk,
                                           input logic fpu_err);
      logic pin;
      pin = 1'h0;
      if (stop_req) begin
         pin = brk;
      end else begin
         pin = fpu_err;
      end
      return pin;
   endfunction : pick_err_break

   // a masked error never reaches the pin, whatever the stop request says
   // the mask is applied before the mux so a break event is never masked
   assign fpu_unmasked   = fpu_error & ~fpu_error_masked;

   // only the first rise of the fault may start a shutdown cycle
   // a second error after the first finds fault_reg set and is ignored here
   assign fault_rise     = internal_error & ~fault_reg;

   // phase and stall are read from the shared pins, never from this end's own results
   assign phase_open     = pins.snoop_phase;
   assign wires_both     = is_stall(pins.snoop_hit_wire, pins.snoop_modified_hit_wire);

   assign err_break_next = pick_err_break(pins.clock_stop_request, break_pending, fpu_unmasked);

   // a stall is asked for again every cycle of the phase while more time is needed;
   // dropping snoop_need_stall lets the real result go out on the next edge
   assign result_next    = pick_result(phase_open, snoop_need_stall, snoop_modified_line, snoop_hit_line);

   // the fault only accumulates; nothing but reset takes it away
   assign fault_next     = fault_reg | internal_error;
   // shutdown_enable off keeps the fault visible but leaves the bus cycle out
   assign shutdown_next  = fault_rise & shutdown_enable;

   // error/break pin follows its selected source one cycle later
   // both meanings share one flip-flop, so a change of stop request takes one cycle to show
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         err_break_reg <= 1'h0;
      end else begin
         err_break_reg <= err_break_next;
      end
   end

   // sticky fault; repeated internal errors while it is set change nothing
   // an error in the reset cycle is lost, reset has the last word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_reg <= 1'h0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   // shutdown cycle is a one-cycle pulse, on the first fault only
   // it rises on the same edge as the fault pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shutdown_reg <= 1'h0;
      end else begin
         shutdown_reg <= shutdown_next;
      end
   end

   // results are registered, so they reach the pins one cycle into the phase;
   // the core end waits that cycle out before it judges the wires
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_reg <= CESP_SNOOP_CLEAN;
      end else begin
         result_reg <= result_next;
      end
   end

   // open-drain style: the level is always asserted, the enable says whether this end drives
   // the pins are left released after reset and from the second cycle after each phase on
   assign pins.snoop_hit_out          = 1'h1;
   assign pins.snoop_modified_hit_out = 1'h1;
   assign pins.snoop_hit_oe           = drives_hit(result_reg);
   assign pins.snoop_modified_hit_oe  = drives_modified(result_reg);

   // status pins: each is a plain copy of its flip-flop
   // so the far end may sample them on any edge
   assign pins.fpu_error_break_pending_out = err_break_reg;
   assign pins.internal_fault_out          = fault_reg;
   assign pins.shutdown_cycle              = shutdown_reg;

   // any agent may hold the stall, so it is judged from the wired-or pins, not from result_reg
   assign snoop_stalled = phase_open & wires_both;
   assign fault_sticky  = fault_reg;
endmodule : cesp_cpu_end

//--- hw/cesp_defs.svh
// timing counts and pin-level constants for the cpu status pins
`ifndef CESP_DEFS_SVH
`define CESP_DEFS_SVH
`define CESP_SNOOP_LAT_NS   10
`define CESP_CLK_NS         5
`define CESP_SNOOP_LAT_CYC  ((`CESP_SNOOP_LAT_NS + `CESP_CLK_NS - 1) / `CESP_CLK_NS)
`define CESP_IDLE_RESULT    2'h0
`define CESP_STALL_RESULT   2'h3
`endif

//--- hw/cesp_if.sv
// pins between the processor end and the core logic end
`timescale 1ns/100ps
interface cesp_if;
   logic fpu_error_break_pending_out;
   logic clock_stop_request;
   logic snoop_hit_out;
   logic snoop_hit_oe;
   logic snoop_modified_hit_out;
   logic snoop_modified_hit_oe;
   logic core_hit_out;
   logic core_hit_oe;
   logic core_modified_out;
   logic core_modified_oe;
   logic snoop_phase;
   logic internal_fault_out;
   logic shutdown_cycle;
   wire  snoop_hit_wire;
   wire  snoop_modified_hit_wire;
   assign snoop_hit_wire          = (snoop_hit_oe & snoop_hit_out) | (core_hit_oe & core_hit_out);
   assign snoop_modified_hit_wire = (snoop_modified_hit_oe & snoop_modified_hit_out)
                                  | (core_modified_oe & core_modified_out);
   modport cpu (
      output fpu_error_break_pending_out, snoop_hit_out, snoop_hit_oe, snoop_modified_hit_out,
             snoop_modified_hit_oe, internal_fault_out, shutdown_cycle,
      input  clock_stop_request, snoop_phase, snoop_hit_wire, snoop_modified_hit_wire
   );
   modport core (
      output clock_stop_request, snoop_phase, core_hit_out, core_hit_oe, core_modified_out,
             core_modified_oe,
      input  fpu_error_break_pending_out, internal_fault_out, shutdown_cycle, snoop_hit_wire,
             snoop_modified_hit_wire
   );
endinterface : cesp_if

//--- hw/cesp_pkg.sv
// types shared by both ends of the cpu status pins
package cesp_pkg;
   typedef enum logic [1:0] {
      CESP_SNOOP_CLEAN,
      CESP_SNOOP_SHARED,
      CESP_SNOOP_MODIFIED,
      CESP_SNOOP_STALL
   } cesp_snoop_t;
   typedef enum {CESP_IDLE, CESP_WAIT, CESP_DONE} cesp_obs_state_t;
endpackage : cesp_pkg

//--- test/cesp_assertions.sv
// concurrent checks on the pins between the two ends
`timescale 1ns/100ps
module cesp_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic snoop_phase,
   input wire logic snoop_hit_oe,
   input wire logic snoop_modified_hit_oe,
   input wire logic snoop_hit_wire,
   input wire logic snoop_modified_hit_wire,
   input wire logic internal_fault_out,
   input wire logic shutdown_cycle
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   fault_hold_a: assert property (internal_fault_out |=> internal_fault_out)
      else $error("fault dropped");
   fault_clear_a: assert property ($fell(sys_rst) |-> !internal_fault_out)
      else $error("fault after reset");
   shutdown_pulse_a: assert property (shutdown_cycle |=> !shutdown_cycle)
      else $error("shutdown too long");
   shutdown_first_a: assert property (shutdown_cycle |-> internal_fault_out &&
      !$past(internal_fault_out)) else $error("shutdown not after first fault");
   wait_first_a: assert property ($rose(snoop_phase) |=> snoop_phase)
      else $error("phase ended before results");
   hit_oe_phase_a: assert property (snoop_hit_oe |-> $past(snoop_phase))
      else $error("hit outside snoop");
   mod_oe_phase_a: assert property (snoop_modified_hit_oe |-> $past(snoop_phase))
      else $error("modified outside snoop");
   oe_late_a: assert property ($rose(snoop_phase) |-> !snoop_hit_oe && !snoop_modified_hit_oe)
      else $error("result too early");
   stall_hold_a: assert property (snoop_phase && snoop_hit_wire && snoop_modified_hit_wire |=> snoop_phase)
      else $error("stall not honoured");
endmodule : cesp_assertions

//--- test/tb.sv
// self-checking bench joining the processor end and the core logic end
`timescale 1ns/100ps
module tb;
   logic       clk = 0, sys_rst = 1;
   logic       fe = 0, fm = 0, bp = 0, ie = 0, se = 1, ns = 0, hl = 0, ml = 0, sc = 0, ss = 0, cs = 0, ne = 1;
   logic       stalled, sticky, busy, done, sh, md, nmi, fes, bks, fs;
   int         miscompares = 0, n_checks = 0, n_sd = 0, n_nmi = 0;
   logic [4:0] rows [6] = '{5'h09, 5'h0E, 5'h02, 5'h13, 5'h18, 5'h10};
   always #2.5 clk = ~clk;
   cesp_if pins_if ();
   cesp_cpu_end u_cesp_cpu_end (.clk(clk), .sys_rst(sys_rst), .pins(pins_if.cpu), .fpu_error(fe),
      .fpu_error_masked(fm), .break_pending(bp), .internal_error(ie), .shutdown_enable(se),
      .snoop_need_stall(ns), .snoop_hit_line(hl), .snoop_modified_line(ml), .snoop_stalled(stalled),
      .fault_sticky(sticky));
   cesp_core_end u_cesp_core_end (.clk(clk), .sys_rst(sys_rst), .pins(pins_if.core), .stop_clock(sc),
      .snoop_start(ss), .core_stall(cs), .nmi_enable(ne), .snoop_busy(busy), .snoop_done(done),
      .snoop_shared(sh), .snoop_modified(md), .nmi_out(nmi), .fpu_error_seen(fes), .break_seen(bks),
      .fault_seen(fs));
   cesp_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .snoop_phase(pins_if.snoop_phase),
      .snoop_hit_oe(pins_if.snoop_hit_oe), .snoop_modified_hit_oe(pins_if.snoop_modified_hit_oe),
      .snoop_hit_wire(pins_if.snoop_hit_wire), .snoop_modified_hit_wire(pins_if.snoop_modified_hit_wire),
      .internal_fault_out(pins_if.internal_fault_out), .shutdown_cycle(pins_if.shutdown_cycle));
   always @(posedge clk) begin
      if (pins_if.shutdown_cycle === 1'h1) n_sd++;
      if (nmi === 1'h1) n_nmi++;
   end
   task automatic final_report;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // stall is set before the start so the clean early finish is never taken
   task automatic snoop(input logic c_st, k_st, h, m, e_sh, e_md);
      int i;
      ns = c_st; cs = k_st; hl = h; ml = m; ss = 1;
      tick(1);
      ss = 0;
      tick(6);
      if (c_st) chk(stalled, 1'h1);
      chk(busy, 1'h1);
      ns = 0; cs = 0;
      for (i = 0; i < 20 && done !== 1'h1; i++) tick(1);
      chk(done, 1'h1);
      chk(sh, e_sh);
      chk(md, e_md);
      tick(3);
   endtask : snoop
   initial begin
      #50000;
      miscompares++;
      final_report();
   end
   initial begin
      tick(10);
      chk(pins_if.internal_fault_out, 1'h0);
      sys_rst = 0;
      tick(1);
      foreach (rows[i]) begin
         {sc, fe, fm, bp} = rows[i][4:1];
         tick(4);
         chk(pins_if.fpu_error_break_pending_out, rows[i][0]);
         chk(fes, rows[i][0] & ~sc);
         chk(bks, rows[i][0] & sc);
      end
      snoop(1, 0, 0, 0, 0, 0);
      snoop(1, 0, 1, 0, 1, 0);
      snoop(0, 1, 0, 1, 0, 1);
      snoop(1, 1, 1, 1, 0, 1);
      ie = 1;
      tick(1);
      ie = 0;
      tick(3);
      chk(pins_if.internal_fault_out, 1'h1);
      chk(sticky, 1'h1);
      chk(fs, 1'h1);
      tick(20);
      chk(pins_if.internal_fault_out, 1'h1);
      ie = 1;
      tick(1);
      ie = 0;
      tick(4);
      chk(n_sd == 1, 1'h1);
      chk(n_nmi == 1, 1'h1);
      sys_rst = 1;
      tick(2);
      sys_rst = 0;
      tick(1);
      chk(pins_if.internal_fault_out, 1'h0);
      chk(fs, 1'h0);
      final_report();
   end
endmodule : tb
